// ---- src/rsf_axil_slave.v ----
`timescale 1ns/100ps
`include "rsf_regs.vh"

module rsf_axil_slave #(
   parameter AW = 8
) (
   // Clock and reset.
   input  wire          clk,
   input  wire          rst_b,
   // Write address and data channels.
   input  wire [AW-1:0] i_awaddr,
   input  wire          i_awvalid,
   output reg           o_awready,
   input  wire [31:0]   i_wdata,
   input  wire [3:0]    i_wstrb,
   input  wire          i_wvalid,
   output reg           o_wready,
   // Write response channel.
   output reg  [1:0]    o_bresp,
   output reg           o_bvalid,
   input  wire          i_bready,
   // Read channels.
   input  wire [AW-1:0] i_araddr,
   input  wire          i_arvalid,
   output reg           o_arready,
   output reg  [31:0]   o_rdata,
   output reg  [1:0]    o_rresp,
   output reg           o_rvalid,
   input  wire          i_rready,
   // Register file side.
   output wire          o_wr_en,
   output reg  [AW-1:0] o_wr_addr,
   output reg  [31:0]   o_wr_data,
   output reg  [3:0]    o_wr_strb,
   input  wire          i_wr_err,
   output wire [AW-1:0] o_rd_addr,
   input  wire [31:0]   i_rd_data,
   input  wire          i_rd_err
);
   // A ready low means that channel's item is held here.
   assign o_wr_en   = ~o_awready & ~o_wready & ~o_bvalid;
   assign o_rd_addr = i_araddr;

   // Address and data may come in either order; response follows both.
   always @(posedge clk) begin
      if (!rst_b) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= `RSF_RESP_OKAY;
         o_wr_addr <= {AW{1'b0}};
         o_wr_data <= 32'h00000000;
         o_wr_strb <= 4'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            o_awready <= 1'b0;
            o_wr_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            o_wready  <= 1'b0;
            o_wr_data <= i_wdata;
            o_wr_strb <= i_wstrb;
         end
         if (o_wr_en) begin
            o_bvalid <= 1'b1;
            o_bresp  <= i_wr_err ? `RSF_RESP_SLVERR : `RSF_RESP_OKAY;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   // Read data is captured at the address handshake.
   always @(posedge clk) begin
      if (!rst_b) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h00000000;
         o_rresp   <= `RSF_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= i_rd_data;
         o_rresp   <= i_rd_err ? `RSF_RESP_SLVERR : `RSF_RESP_OKAY;
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end
endmodule // rsf_axil_slave

// ---- src/rsf_fuse_ctrl.v ----
// Behaviour
// - Brown-out sleep code 01 is sampled, 10 continuous, 11 off, 00 reserved.
// - The brown-out sleep code governs every sleep mode except idle.
// - A programmed reset-pin-disable fuse stops the pin from causing reset.
// - A changed reset-pin-disable fuse reads back new only after a reset.
// - Internal reset is held by a counter after all sources release.
// - That counter runs on the 1 kHz low-power oscillator, not the clock.
// - Start-up code 00 gives 64 ticks, 01 gives 4, 11 gives 0, 10 reserved.
// - A changed start-up field reads back new only after a reset.
// - A programmed watchdog lock rejects all watchdog configuration writes.
// - With the lock, watchdog enable is set at reset and cannot be cleared.
`timescale 1ns/100ps
`include "rsf_regs.vh"

module rsf_fuse_ctrl (
   // Clock and reset.
   input  wire        I_CLOCK,
   input  wire        I_RST_B,
   // AXI4-Lite write address and data.
   input  wire [7:0]  I_AWADDR,
   input  wire        I_AWVALID,
   output wire        O_AWREADY,
   input  wire [31:0] I_WDATA,
   input  wire [3:0]  I_WSTRB,
   input  wire        I_WVALID,
   output wire        O_WREADY,
   // AXI4-Lite write response.
   output wire [1:0]  O_BRESP,
   output wire        O_BVALID,
   input  wire        I_BREADY,
   // AXI4-Lite read.
   input  wire [7:0]  I_ARADDR,
   input  wire        I_ARVALID,
   output wire        O_ARREADY,
   output wire [31:0] O_RDATA,
   output wire [1:0]  O_RRESP,
   output wire        O_RVALID,
   input  wire        I_RREADY,
   // Reset sources and oscillator.
   input  wire        I_EXT_RESET_B,
   input  wire        I_SYS_RST_REQ,
   input  wire        I_LP_OSC_1KHZ,
   // Sleep state and awake brown-out request.
   input  wire        I_SLEEP,
   input  wire        I_SLEEP_IDLE,
   input  wire        I_BOD_AWAKE_EN,
   // Internal reset, brown-out and watchdog controls.
   output wire        O_INT_RESET,
   output reg         O_BOD_EN,
   output reg         O_BOD_SAMPLED,
   output reg         O_WDT_ENABLE,
   output reg  [3:0]  O_WDT_PERIOD
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   // Offsets held at bus width so that the word index is a clean slice.
   localparam [7:0] OFS_RST  = `RSF_OFS_RSTFUSE;
   localparam [7:0] OFS_BOD  = `RSF_OFS_BODFUSE;
   localparam [7:0] OFS_WDT  = `RSF_OFS_WDTCTRL;
   localparam [7:0] OFS_STAT = `RSF_OFS_STATUS;

   wire        wr_en;
   wire [7:0]  wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   wire [7:0]  rd_addr;
   reg         wr_err;
   reg         rd_err;
   reg  [31:0] rd_data;

   // Programmed fuse bytes, and the copies that act and read back.
   reg  [7:0]  rst_fuse_q;
   reg  [7:0]  bod_fuse_q;
   reg  [7:0]  rst_act_q;
   reg  [7:0]  bod_act_q;

   // Oscillator edge detection and reset sources.
   reg         lp_osc_q;
   wire        lp_tick;
   wire        ext_rst_req;
   wire        src_hold;

   // Decoded fuse meanings.
   wire        ext_dis_act;
   wire        wdt_lock_act;
   wire [1:0]  su_prog;
   wire [1:0]  bod_code;

   // Reset cause flags, cleared by writing one.
   reg         cause_ext_q;
   reg         cause_sys_q;

   // Decoded write strobes.
   wire        wr_byte0;
   wire        wr_rst;
   wire        wr_bod;
   wire        wr_wdt;
   wire        wr_stat;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave.

   rsf_axil_slave #(
      .AW        (8)
   ) u_bus (
      .clk       (I_CLOCK),
      .rst_b     (I_RST_B),
      .i_awaddr  (I_AWADDR),
      .i_awvalid (I_AWVALID),
      .o_awready (O_AWREADY),
      .i_wdata   (I_WDATA),
      .i_wstrb   (I_WSTRB),
      .i_wvalid  (I_WVALID),
      .o_wready  (O_WREADY),
      .o_bresp   (O_BRESP),
      .o_bvalid  (O_BVALID),
      .i_bready  (I_BREADY),
      .i_araddr  (I_ARADDR),
      .i_arvalid (I_ARVALID),
      .o_arready (O_ARREADY),
      .o_rdata   (O_RDATA),
      .o_rresp   (O_RRESP),
      .o_rvalid  (O_RVALID),
      .i_rready  (I_RREADY),
      .o_wr_en   (wr_en),
      .o_wr_addr (wr_addr),
      .o_wr_data (wr_data),
      .o_wr_strb (wr_strb),
      .i_wr_err  (wr_err),
      .o_rd_addr (rd_addr),
      .i_rd_data (rd_data),
      .i_rd_err  (rd_err)
   );

   ////////////////////////////////////////////////////////////////////////
   // Address decode.

   // Only the word address matters; the low two bits are ignored.
   assign wr_byte0 = wr_en & wr_strb[0];
   assign wr_rst   = wr_byte0 & (wr_addr[7:2] == OFS_RST[7:2]);
   assign wr_bod   = wr_byte0 & (wr_addr[7:2] == OFS_BOD[7:2]);
   assign wr_wdt   = wr_byte0 & (wr_addr[7:2] == OFS_WDT[7:2]);
   assign wr_stat  = wr_byte0 & (wr_addr[7:2] == OFS_STAT[7:2]);

   // Unmapped writes answer with an error and change nothing.
   always @* begin
      case (wr_addr[7:2])
         OFS_RST[7:2]:  wr_err = 1'b0;
         OFS_BOD[7:2]:  wr_err = 1'b0;
         OFS_WDT[7:2]:  wr_err = 1'b0;
         OFS_STAT[7:2]: wr_err = 1'b0;
         default:               wr_err = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Fuse storage.

   // reserved bits kept
   // Reserved bits are stored as written, so a careless write stays visible
   // in the read-back and software can catch its own mistake.
   always @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         rst_fuse_q <= `RSF_FUSE_ERASED;
         bod_fuse_q <= `RSF_FUSE_ERASED;
      end else begin
         if (wr_rst) begin
            rst_fuse_q <= wr_data[7:0];
         end
         if (wr_bod) begin
            bod_fuse_q <= wr_data[7:0];
         end
      end
   end

   // read back after reset
   // The acting copy follows the programmed bytes only while a reset
   // source is held, so a fresh value appears after the next reset.
   always @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         rst_act_q <= `RSF_FUSE_ERASED;
         bod_act_q <= `RSF_FUSE_ERASED;
      end else if (src_hold) begin
         rst_act_q <= rst_fuse_q;
         bod_act_q <= bod_fuse_q;
      end
   end

   assign ext_dis_act  = ~rst_act_q[`RSF_BIT_EXT_DIS];
   assign wdt_lock_act = ~rst_act_q[`RSF_BIT_WDT_LOCK];
   assign bod_code     = bod_act_q[`RSF_BIT_BOD_MSB:`RSF_BIT_BOD_LSB];

   // The counter loads from the programmed byte, since the acting copy is
   // refreshed on the very same edges and would lag by one cycle.
   assign su_prog = rst_fuse_q[`RSF_BIT_SU_MSB:`RSF_BIT_SU_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Reset sources and start-up delay.

   assign ext_rst_req = ~I_EXT_RESET_B & ~ext_dis_act;
   assign src_hold    = ext_rst_req | I_SYS_RST_REQ;

   // oscillator edge
   // The oscillator level is synchronous here, so one flop finds the edge.
   always @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         lp_osc_q <= 1'b0;
      end else begin
         lp_osc_q <= I_LP_OSC_1KHZ;
      end
   end

   assign lp_tick = I_LP_OSC_1KHZ & ~lp_osc_q;

   rsf_startup_delay u_delay (
      .clk      (I_CLOCK),
      .rst_b    (I_RST_B),
      .i_hold   (src_hold),
      .i_tick   (lp_tick),
      .i_sel    (su_prog),
      .o_active (O_INT_RESET)
   );

   ////////////////////////////////////////////////////////////////////////
   // Reset cause flags.

   // A new cause in the cycle of a clear wins, so no reset goes unseen.
   always @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         cause_ext_q <= 1'b0;
         cause_sys_q <= 1'b0;
      end else begin
         if (ext_rst_req) begin
            cause_ext_q <= 1'b1;
         end else if (wr_stat && wr_data[0]) begin
            cause_ext_q <= 1'b0;
         end
         if (I_SYS_RST_REQ) begin
            cause_sys_q <= 1'b1;
         end else if (wr_stat && wr_data[1]) begin
            cause_sys_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog configuration.

   // enable forced at reset
   // A locked write still answers OKAY; only the content is refused.
   always @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         O_WDT_ENABLE <= 1'b0;
         O_WDT_PERIOD <= `RSF_WDT_PER_RST;
      end else if (O_INT_RESET) begin
         O_WDT_ENABLE <= wdt_lock_act;
         O_WDT_PERIOD <= `RSF_WDT_PER_RST;
      end else if (wr_wdt && !wdt_lock_act) begin
         O_WDT_ENABLE <= wr_data[0];
         O_WDT_PERIOD <= wr_data[4:1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Brown-out detector control.

   // not in idle
   // The reserved code turns the detector off rather than guessing a mode.
   always @(posedge I_CLOCK) begin
      if (!I_RST_B) begin
         O_BOD_EN      <= 1'b0;
         O_BOD_SAMPLED <= 1'b0;
      end else if (I_SLEEP && !I_SLEEP_IDLE) begin
         case (bod_code)
            `RSF_BOD_SAMPLED: begin
               O_BOD_EN      <= 1'b1;
               O_BOD_SAMPLED <= 1'b1;
            end
            `RSF_BOD_CONT: begin
               O_BOD_EN      <= 1'b1;
               O_BOD_SAMPLED <= 1'b0;
            end
            default: begin
               O_BOD_EN      <= 1'b0;
               O_BOD_SAMPLED <= 1'b0;
            end
         endcase
      end else begin
         O_BOD_EN      <= I_BOD_AWAKE_EN;
         O_BOD_SAMPLED <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data.

   // Fuse reads return the acting copies; status shows live state.
   always @* begin
      rd_data = 32'h00000000;
      rd_err  = 1'b0;
      case (rd_addr[7:2])
         OFS_RST[7:2]: begin
            rd_data[7:0] = rst_act_q;
         end
         OFS_BOD[7:2]: begin
            rd_data[7:0] = bod_act_q;
         end
         OFS_WDT[7:2]: begin
            rd_data[0]   = O_WDT_ENABLE;
            rd_data[4:1] = O_WDT_PERIOD;
         end
         OFS_STAT[7:2]: begin
            rd_data[0]   = cause_ext_q;
            rd_data[1]   = cause_sys_q;
            rd_data[2]   = O_INT_RESET;
            rd_data[3]   = ext_dis_act;
            rd_data[4]   = wdt_lock_act;
            rd_data[6:5] = bod_code;
            rd_data[7]   = (bod_code == `RSF_BOD_RSVD);
            rd_data[9:8] = rst_act_q[`RSF_BIT_SU_MSB:`RSF_BIT_SU_LSB];
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

endmodule // rsf_fuse_ctrl

// ---- src/rsf_regs.vh ----
`ifndef RSF_REGS_VH
`define RSF_REGS_VH
// Register byte offsets.
`define RSF_OFS_RSTFUSE     8'h04
`define RSF_OFS_BODFUSE     8'h08
`define RSF_OFS_WDTCTRL     8'h0C
`define RSF_OFS_STATUS      8'h10
// Erased fuse byte and other reset values.
`define RSF_FUSE_ERASED     8'hFF
`define RSF_WDT_PER_RST     4'h0
// Fuse field positions.
`define RSF_BIT_WDT_LOCK    1
`define RSF_BIT_SU_LSB      2
`define RSF_BIT_SU_MSB      3
`define RSF_BIT_EXT_DIS     4
`define RSF_BIT_BOD_LSB     0
`define RSF_BIT_BOD_MSB     1
// Brown-out sleep codes.
`define RSF_BOD_RSVD        2'h0
`define RSF_BOD_SAMPLED     2'h1
`define RSF_BOD_CONT        2'h2
`define RSF_BOD_OFF         2'h3
// Start-up codes and their delays in oscillator cycles.
`define RSF_SU_64           2'h0
`define RSF_SU_4            2'h1
`define RSF_SU_RSVD         2'h2
`define RSF_SU_0            2'h3
`define RSF_DLY_64          7'h40
`define RSF_DLY_4           7'h04
`define RSF_DLY_0           7'h00
// Bus responses.
`define RSF_RESP_OKAY       2'h0
`define RSF_RESP_SLVERR     2'h2
`endif

// ---- src/rsf_startup_delay.v ----
`timescale 1ns/100ps
`include "rsf_regs.vh"

module rsf_startup_delay (
   // Clock and reset.
   input  wire       clk,
   input  wire       rst_b,
   // Reset sources, oscillator tick and delay code.
   input  wire       i_hold,
   input  wire       i_tick,
   input  wire [1:0] i_sel,
   // Internal reset.
   output reg        o_active
);
   localparam CNT_W = 7;

   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] load_val;

   // The reserved code takes the longest delay, the safe side.
   always @* begin
      case (i_sel)
         `RSF_SU_4: load_val = `RSF_DLY_4;
         `RSF_SU_0: load_val = `RSF_DLY_0;
         default:   load_val = `RSF_DLY_64;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_b || i_hold) begin
         cnt_q    <= load_val;
         o_active <= 1'b1;
      end else if (cnt_q == 7'h00) begin
         o_active <= 1'b0;
      end else if (i_tick) begin
         cnt_q <= cnt_q - 7'h01;
      end
   end
endmodule // rsf_startup_delay

// ---- test/rsf_fuse_ctrl_bench.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
module reset_startup_fuse_config_bench;
   logic I_CLOCK, I_RST_B, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID;
   logic I_RREADY, I_EXT_RESET_B, I_SYS_RST_REQ, I_LP_OSC_1KHZ, I_SLEEP;
   logic I_SLEEP_IDLE, I_BOD_AWAKE_EN, osc_prev;
   logic [7:0]  I_AWADDR, I_ARADDR;
   logic [31:0] I_WDATA, rdv;
   logic [3:0]  I_WSTRB;
   logic [2:0]  osc_cnt;
   int          n_mismatch, tests_run;
   rsf_fuse_ctrl dut (.I_CLOCK, .I_RST_B, .I_AWADDR, .I_AWVALID,
      .O_AWREADY(), .I_WDATA, .I_WSTRB, .I_WVALID, .O_WREADY(), .O_BRESP(),
      .O_BVALID(), .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY(),
      .O_RDATA(), .O_RRESP(), .O_RVALID(), .I_RREADY, .I_EXT_RESET_B,
      .I_SYS_RST_REQ, .I_LP_OSC_1KHZ, .I_SLEEP, .I_SLEEP_IDLE,
      .I_BOD_AWAKE_EN, .O_INT_RESET(), .O_BOD_EN(), .O_BOD_SAMPLED(),
      .O_WDT_ENABLE(), .O_WDT_PERIOD());
   // Clock; the oscillator is sped up to one tick in eight cycles.
   always #5 I_CLOCK = ~I_CLOCK;
   always @(posedge I_CLOCK) begin
      osc_cnt       <= osc_cnt + 3'h1;
      I_LP_OSC_1KHZ <= osc_cnt[2];
      osc_prev      <= I_LP_OSC_1KHZ;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One bus transfer; ready lines are sampled at the edge, before updates.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge I_CLOCK);
      if (wr) begin
         I_AWADDR <= a; I_WDATA <= d; I_AWVALID <= 1'b1;
         I_WVALID <= 1'b1; I_BREADY <= 1'b1;
      end else begin
         I_ARADDR <= a; I_ARVALID <= 1'b1; I_RREADY <= 1'b1;
      end
      for (k = 0; k < 60; k++) begin
         @(posedge I_CLOCK);
         if (I_AWVALID && dut.O_AWREADY) I_AWVALID <= 1'b0;
         if (I_WVALID && dut.O_WREADY) I_WVALID <= 1'b0;
         if (I_ARVALID && dut.O_ARREADY) I_ARVALID <= 1'b0;
         if (wr ? dut.O_BVALID : dut.O_RVALID) break;
      end
      // A transfer that never answers counts against the run.
      chk(k < 60, 1'b1);
      rdv = dut.O_RDATA;
      chk(wr ? dut.O_BRESP : dut.O_RRESP, er);
      I_BREADY <= 1'b0;
      I_RREADY <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 2'h0);
      chk(rdv, e);
   endtask
   // System reset; counts ticks between source release and reset release.
   task automatic rst_seq(input int n);
      int t;
      @(posedge I_CLOCK);
      I_SYS_RST_REQ <= 1'b1;
      repeat (3) @(posedge I_CLOCK);
      while (!(I_LP_OSC_1KHZ && !osc_prev)) @(posedge I_CLOCK);
      I_SYS_RST_REQ <= 1'b0;
      t = 0;
      repeat (2000) begin
         @(posedge I_CLOCK);
         if (!dut.O_INT_RESET) break;
         if (I_LP_OSC_1KHZ && !osc_prev) t++;
      end
      chk(dut.O_INT_RESET, 1'b0);
      chk(t, n);
   endtask
   task automatic pin_low(input logic e);
      @(posedge I_CLOCK);
      I_EXT_RESET_B <= 1'b0;
      repeat (3) @(posedge I_CLOCK);
      chk(dut.O_INT_RESET, e);
      I_EXT_RESET_B <= 1'b1;
      repeat (4) @(posedge I_CLOCK);
   endtask
   task automatic t_erased;
      repeat (3) @(posedge I_CLOCK);
      chk(dut.O_INT_RESET, 1'b0);
      rd(8'h04, 32'h0000_00FF);
      rd(8'h08, 32'h0000_00FF);
      bus(1'b0, 8'h40, 32'h0, 2'h2);
      chk(rdv, 32'h0);
      // An unmapped write answers with an error and leaves fuses alone.
      bus(1'b1, 8'h40, 32'h0, 2'h2);
      rd(8'h04, 32'h0000_00FF);
   endtask
   // Every start-up code; old value must read back until the reset.
   task automatic t_startup;
      logic [7:0] prev, v;
      int dl [4] = '{64, 4, 64, 0};
      prev = 8'hFF;
      for (int c = 0; c < 4; c++) begin
         v = 8'hF3 | (c[7:0] << 2);
         bus(1'b1, 8'h04, {24'h0, v}, 2'h0);
         rd(8'h04, {24'h0, prev});
         rst_seq(dl[c]);
         rd(8'h04, {24'h0, v});
         prev = v;
      end
   endtask
   task automatic t_pin;
      pin_low(1'b1);
      bus(1'b1, 8'h04, 32'h0000_00EF, 2'h0);
      rd(8'h04, 32'h0000_00FF);
      rst_seq(0);
      rd(8'h04, 32'h0000_00EF);
      pin_low(1'b0);
      // Both causes seen, pin disable active; then clear both by one write.
      rd(8'h10, 32'h0000_036B);
      bus(1'b1, 8'h10, 32'h0000_0003, 2'h0);
      rd(8'h10, 32'h0000_0368);
   endtask
   task automatic t_wdt;
      bus(1'b1, 8'h04, 32'h0000_00FF, 2'h0);
      rst_seq(0);
      bus(1'b1, 8'h0C, 32'h0000_0013, 2'h0);
      rd(8'h0C, 32'h0000_0013);
      bus(1'b1, 8'h04, 32'h0000_00FD, 2'h0);
      rst_seq(0);
      chk(dut.O_WDT_ENABLE, 1'b1);
      bus(1'b1, 8'h0C, 32'h0000_0000, 2'h0);
      rd(8'h0C, 32'h0000_0001);
      chk(dut.O_WDT_ENABLE, 1'b1);
   endtask
   // Brown-out codes in deep sleep, then idle with the awake request set.
   task automatic t_bod;
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 8'h08, {24'h0, 8'hFC | c[7:0]}, 2'h0);
         rst_seq(0);
         I_SLEEP <= 1'b1;
         repeat (3) @(posedge I_CLOCK);
         chk(dut.O_BOD_EN, c == 1 || c == 2);
         chk(dut.O_BOD_SAMPLED, c == 1);
         I_SLEEP_IDLE <= 1'b1;
         I_BOD_AWAKE_EN <= 1'b1;
         repeat (3) @(posedge I_CLOCK);
         chk({dut.O_BOD_EN, dut.O_BOD_SAMPLED}, 2'h2);
         I_SLEEP <= 1'b0;
         I_SLEEP_IDLE <= 1'b0;
         I_BOD_AWAKE_EN <= 1'b0;
      end
   endtask
   initial begin
      I_CLOCK = 0; I_RST_B = 0; I_AWVALID = 0; I_WVALID = 0; I_BREADY = 0;
      I_ARVALID = 0; I_RREADY = 0; I_EXT_RESET_B = 1; I_SYS_RST_REQ = 0;
      I_LP_OSC_1KHZ = 0; osc_prev = 0; osc_cnt = 3'h0; I_SLEEP = 0;
      I_SLEEP_IDLE = 0; I_BOD_AWAKE_EN = 0; I_AWADDR = 8'h0;
      I_ARADDR = 8'h0; I_WDATA = 32'h0; I_WSTRB = 4'hF;
      n_mismatch = 0; tests_run = 0;
      repeat (2) @(posedge I_CLOCK);
      I_RST_B <= 1'b1;
      t_erased();
      t_startup();
      t_pin();
      t_wdt();
      t_bod();
      give_verdict();
   end
   // Watchdog on a hung run.
   initial begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
endmodule // reset_startup_fuse_config_bench
bind rsf_fuse_ctrl rsf_fuse_ctrl_properties u_props (.I_CLOCK, .I_RST_B,
   .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID,
   .I_ARVALID, .O_ARREADY, .O_RVALID, .I_SYS_RST_REQ, .I_SLEEP,
   .I_SLEEP_IDLE, .I_BOD_AWAKE_EN, .O_INT_RESET, .O_BOD_EN,
   .O_BOD_SAMPLED, .O_WDT_PERIOD);

// ---- test/rsf_fuse_ctrl_properties.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Port checker for the fuse controller; all in the bus clock domain.
module rsf_fuse_ctrl_properties (
   // Clock, reset and bus.
   input  wire        I_CLOCK,
   input  wire        I_RST_B,
   input  wire        I_AWVALID,
   input  wire        O_AWREADY,
   input  wire        I_WVALID,
   input  wire        O_WREADY,
   input  wire [1:0]  O_BRESP,
   input  wire        O_BVALID,
   input  wire        I_ARVALID,
   input  wire        O_ARREADY,
   input  wire        O_RVALID,
   // Reset, sleep and outputs.
   input  wire        I_SYS_RST_REQ,
   input  wire        I_SLEEP,
   input  wire        I_SLEEP_IDLE,
   input  wire        I_BOD_AWAKE_EN,
   input  wire        O_INT_RESET,
   input  wire        O_BOD_EN,
   input  wire        O_BOD_SAMPLED,
   input  wire [3:0]  O_WDT_PERIOD
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_B);
   // The write answer is raised on the edge after a joint take, so it is
   // first seen high two edges after the take.
   property p_bvalid;
      I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID;
   endproperty
   a_bvalid: assert property (p_bvalid) else $error("write answer late");
   property p_rvalid;
      I_ARVALID && O_ARREADY |=> O_RVALID;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer late");
   // A pending answer refuses new requests.
   property p_brefuse;
      O_BVALID |-> !O_AWREADY && !O_WREADY;
   endproperty
   a_brefuse: assert property (p_brefuse) else $error("write not refused");
   property p_rrefuse;
      O_RVALID |-> !O_ARREADY;
   endproperty
   a_rrefuse: assert property (p_rrefuse) else $error("read not refused");
   property p_src;
      I_SYS_RST_REQ |=> O_INT_RESET;
   endproperty
   a_src: assert property (p_src) else $error("reset not held");
   property p_fall;
      $fell(O_INT_RESET) |-> !$past(I_SYS_RST_REQ);
   endproperty
   a_fall: assert property (p_fall) else $error("early release");
   property p_bodok;
      !I_SLEEP || I_SLEEP_IDLE |=>
         O_BOD_EN == $past(I_BOD_AWAKE_EN) && !O_BOD_SAMPLED;
   endproperty
   a_bodok: assert property (p_bodok) else $error("awake detector");
   property p_samp;
      O_BOD_SAMPLED |-> O_BOD_EN;
   endproperty
   a_samp: assert property (p_samp) else $error("sampled while off");
   property p_wdt;
      O_INT_RESET ##1 O_INT_RESET |-> O_WDT_PERIOD == 4'h0;
   endproperty
   a_wdt: assert property (p_wdt) else $error("period not reset");
   // Main scenarios reached.
   c_fall: cover property ($fell(O_INT_RESET));
   c_samp: cover property (O_BOD_SAMPLED);
   c_err: cover property (O_BVALID && O_BRESP == 2'h2);
endmodule // rsf_fuse_ctrl_properties
